// >>> rtl/burst_bus_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Guard low at reset end floats everything
// R2 - Upper select bits 15:8, lower 7:0
// R3 - Selects mark participating bytes each transfer
// R4 - Failure shown as final marker, no lanes
// R5 - Failure shown only before first transaction
// R6 - Failure held during self-test, cleared on pass
// R7 - Checksum eight words; mismatch fails forever
// R8 - Float lines first, then grant, then yield
// R9 - Request dropped: grant low, idle or address
// R10 - Grant driven except in float mode, low in reset
// R11 - Final marker low through last transfer, waits
// R12 - Master drives lines only while granted
// R13 - No ready: insert wait phase, repeat
// R14 - Word index increments each burst word
module burst_bus_unit #(
  parameter int unsigned SELFTEST_CYCLES = burst_bus_pkg::SELFTEST_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Core requests
  input wire logic req_valid,
  output logic req_ready,
  input wire burst_bus_pkg::bus_req_t req,
  input wire logic wdata_valid,
  output logic wdata_ready,
  input wire logic [burst_bus_pkg::DATA_W-1:0] wdata,
  output logic rdata_valid,
  input wire logic rdata_ready,
  output logic [burst_bus_pkg::DATA_W-1:0] rdata,
  // Initialisation status
  input wire logic selftest_fault,
  output logic init_done,
  output logic init_failed,
  // Bus pins
  input wire logic [burst_bus_pkg::DATA_W-1:0] shared_bus_in,
  input wire logic ready_n,
  input wire logic bus_request,
  input wire logic bus_guard_n,
  output burst_bus_pkg::pins_t pins
);
  import burst_bus_pkg::*;

  function automatic logic start_ok(input logic valid, input logic wr,
                                    input logic wvalid);
    start_ok = valid && (!wr || wvalid);
  endfunction

  // Pin synchronisers: a change counts once stages two and three agree
  logic [2:0] req_s, rdy_s, guard_s;
  logic [DATA_W-1:0] ad_s1, ad_s2, ad_s3;
  logic req_f, rdy_n_f, guard_n_f, once_r;

  always_ff @(posedge clock) begin
    req_s <= {req_s[1:0], bus_request};
    rdy_s <= {rdy_s[1:0], ready_n};
    guard_s <= {guard_s[1:0], bus_guard_n};
    ad_s1 <= shared_bus_in;
    ad_s2 <= ad_s1;
    ad_s3 <= ad_s2;
    if (req_s[1] == req_s[2]) begin
      req_f <= req_s[2];
    end
    if (rdy_s[1] == rdy_s[2]) begin
      rdy_n_f <= rdy_s[2];
    end
    if (guard_s[1] == guard_s[2]) begin
      guard_n_f <= guard_s[2];
    end
    // Strap follows the guard while reset is held, frozen at release
    if (reset) begin
      once_r <= ~guard_n_f; // [R1]
    end
  end

  bus_state_t st_r, st_nxt;
  logic [TEST_CNT_W-1:0] test_cnt_r, test_cnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic write_r, write_nxt, chk_r, chk_nxt, chk2_r, chk2_nxt;
  logic done_r, done_nxt, rdy_used_r, rdy_used_nxt;
  logic [1:0] lanes_r, lanes_nxt;
  logic [IDX_W-1:0] cnt_r, cnt_nxt, idx_r, idx_nxt;
  logic [SUM_W-1:0] sum_r, sum_nxt;
  logic [DATA_W-1:0] wd_r, wd_nxt;
  pins_t pins_r, pins_nxt;
  logic xfer, launch, push, push_ready;

  always_comb begin
    st_nxt = st_r;
    test_cnt_nxt = test_cnt_r;
    addr_nxt = addr_r;
    write_nxt = write_r;
    chk_nxt = chk_r;
    chk2_nxt = chk2_r;
    done_nxt = done_r;
    // A used ready re-arms only once the filtered pin has gone high again
    rdy_used_nxt = rdy_used_r && !rdy_n_f;
    lanes_nxt = lanes_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    sum_nxt = sum_r;
    wd_nxt = wd_r;
    req_ready = 1'h0;
    wdata_ready = 1'h0;
    xfer = 1'h0;
    launch = 1'h0;
    push = 1'h0;
    case (st_r)
      ST_TEST: begin
        test_cnt_nxt = test_cnt_r + 1'h1;
        if (test_cnt_r == TEST_CNT_W'(SELFTEST_CYCLES - 1)) begin // [R6]
          if (selftest_fault) begin
            st_nxt = ST_FAIL;
          end else begin
            st_nxt = ST_ADDR;
            chk_nxt = 1'h1;
            addr_nxt = CHK_FIRST_ADDR;
            write_nxt = 1'h0;
            lanes_nxt = BOTH_LANES;
            cnt_nxt = CHK_LAST_CNT;
            idx_nxt = CHK_FIRST_ADDR[IDX_HI:IDX_LO];
          end
        end
      end
      ST_IDLE: begin
        if (req_f) begin
          st_nxt = ST_FLOAT; // [R8]
        end else begin
          launch = start_ok(req_valid, req.write, wdata_valid);
        end
      end
      ST_ADDR: st_nxt = ST_DATA;
      ST_DATA: begin
        // Without ready the phase repeats as a wait phase; the filtered
        // ready lingers low, so one low stretch pays for one word only
        xfer = !rdy_n_f && !rdy_used_r
               && (write_r ? (cnt_r == '0 || wdata_valid)
                           : (chk_r || push_ready)); // [R13]
        if (xfer) begin
          rdy_used_nxt = 1'h1;
          push = !write_r && !chk_r;
          if (chk_r) begin
            sum_nxt = sum_r + (idx_r[0] ? {ad_s3, {DATA_W{1'h0}}}
                                        : {{DATA_W{1'h0}}, ad_s3});
          end
          if (cnt_r == '0) begin
            if (!chk_r) begin
              st_nxt = ST_IDLE;
            end else if (!chk2_r) begin
              chk2_nxt = 1'h1;
              addr_nxt = CHK_SECOND_ADDR;
              idx_nxt = CHK_SECOND_ADDR[IDX_HI:IDX_LO];
              cnt_nxt = CHK_LAST_CNT;
              st_nxt = ST_ADDR;
            end else begin
              chk_nxt = 1'h0;
              done_nxt = sum_nxt == '0;
              st_nxt = (sum_nxt == '0) ? ST_IDLE : ST_FAIL; // [R7]
            end
          end else begin
            cnt_nxt = cnt_r - 1'h1;
            idx_nxt = idx_r + 1'h1; // [R14]
            if (write_r) begin
              wdata_ready = 1'h1;
              wd_nxt = wdata;
            end
          end
        end
      end
      ST_FLOAT: st_nxt = ST_HOLD; // [R8]
      ST_HOLD: begin
        // Master has already released the lines before dropping its request
        if (!req_f) begin // [R9] [R12]
          st_nxt = ST_IDLE;
          launch = start_ok(req_valid, req.write, wdata_valid);
        end
      end
      ST_FAIL: st_nxt = ST_FAIL;
      default: st_nxt = ST_TEST;
    endcase
    if (launch) begin
      st_nxt = ST_ADDR;
      req_ready = 1'h1;
      addr_nxt = req.addr;
      write_nxt = req.write;
      lanes_nxt = req.lanes;
      cnt_nxt = req.words_m1;
      idx_nxt = req.addr[IDX_HI:IDX_LO];
      if (req.write) begin
        wdata_ready = 1'h1;
        wd_nxt = wdata;
      end
    end
  end

  // Pins follow the next state so they change with the phase itself
  always_comb begin
    pins_nxt = PINS_RESET;
    pins_nxt.burst_final_marker_n = 1'h1;
    pins_nxt.burst_final_oe = 1'h1;
    pins_nxt.byte_lane_selects_n = NO_LANES_N;
    pins_nxt.byte_lane_oe = 1'h1;
    pins_nxt.word_index_lines = idx_nxt;
    pins_nxt.write_not_read = write_nxt;
    pins_nxt.addr_high = addr_nxt[ADDR_W-1:DATA_W];
    case (st_nxt)
      ST_TEST, ST_FAIL: begin
        pins_nxt.burst_final_marker_n = 1'h0; // [R4] [R5] [R6] [R7]
      end
      ST_ADDR: begin
        pins_nxt.shared_bus_lines = addr_nxt[DATA_W-1:0];
        pins_nxt.shared_bus_oe = 1'h1;
        pins_nxt.addr_high_oe = 1'h1;
        pins_nxt.word_index_oe = 1'h1;
        pins_nxt.addr_latch = 1'h1;
        pins_nxt.addr_status_n = 1'h0;
      end
      ST_DATA: begin
        pins_nxt.shared_bus_lines = wd_nxt;
        pins_nxt.shared_bus_oe = write_nxt;
        pins_nxt.addr_high_oe = 1'h1;
        pins_nxt.word_index_oe = 1'h1;
        pins_nxt.data_enable_n = 1'h0;
        pins_nxt.byte_lane_selects_n = ~lanes_nxt; // [R2] [R3]
        pins_nxt.burst_final_marker_n = cnt_nxt != '0; // [R11]
      end
      ST_FLOAT, ST_HOLD: begin
        pins_nxt.burst_final_oe = 1'h0; // [R8]
        pins_nxt.byte_lane_oe = 1'h0;
        pins_nxt.control_oe = 1'h0;
        pins_nxt.bus_grant_out = st_nxt == ST_HOLD; // [R8] [R10]
      end
      default: pins_nxt.bus_grant_out = 1'h0;
    endcase
    if (once_r) begin
      pins_nxt.shared_bus_oe = 1'h0; // [R1]
      pins_nxt.addr_high_oe = 1'h0;
      pins_nxt.word_index_oe = 1'h0;
      pins_nxt.byte_lane_oe = 1'h0;
      pins_nxt.burst_final_oe = 1'h0;
      pins_nxt.control_oe = 1'h0;
      pins_nxt.bus_grant_oe = 1'h0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= ST_TEST;
      test_cnt_r <= '0;
      addr_r <= '0;
      write_r <= 1'h0;
      chk_r <= 1'h0;
      chk2_r <= 1'h0;
      done_r <= 1'h0;
      rdy_used_r <= 1'h0;
      lanes_r <= '0;
      cnt_r <= '0;
      idx_r <= '0;
      sum_r <= '0;
      wd_r <= '0;
      pins_r <= PINS_RESET; // [R10]
    end else begin
      st_r <= st_nxt;
      test_cnt_r <= test_cnt_nxt;
      addr_r <= addr_nxt;
      write_r <= write_nxt;
      chk_r <= chk_nxt;
      chk2_r <= chk2_nxt;
      done_r <= done_nxt;
      rdy_used_r <= rdy_used_nxt;
      lanes_r <= lanes_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      sum_r <= sum_nxt;
      wd_r <= wd_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign pins = pins_r;
  assign init_done = done_r;
  assign init_failed = st_r == ST_FAIL;

  // Read data stalls the bus via push_ready when the core stops draining
  stream_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_read_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(ad_s3),
    .out_valid(rdata_valid),
    .out_ready(rdata_ready),
    .out_data(rdata)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_ONCE_FLOAT: // [R1]
    assert property (once_r && $past(once_r) && !$past(reset)
                     |-> !pins.bus_grant_oe
                     && !pins.shared_bus_oe && !pins.burst_final_oe)
      else $error("outputs driven in float mode");
  AST_LANES: // [R3]
    assert property (st_r == ST_DATA && !once_r
                     |-> pins.byte_lane_selects_n == ~lanes_r)
      else $error("byte lane selects do not match transfer");
  AST_FAIL_SHOWN: // [R4]
    assert property (st_r == ST_FAIL && !once_r |-> !pins.burst_final_marker_n
                     && pins.byte_lane_selects_n == NO_LANES_N)
      else $error("failure combination not shown");
  AST_NO_FAIL_IDLE: // [R5]
    assert property (st_r == ST_IDLE |-> pins.burst_final_marker_n)
      else $error("failure shown after initialisation");
  AST_TEST_PASS: // [R6]
    assert property ($past(st_r) == ST_TEST && st_r == ST_ADDR
                     |-> pins.burst_final_marker_n && chk_r)
      else $error("failure not cleared after self-test");
  AST_FAIL_STICKY: // [R7]
    assert property (st_r == ST_FAIL |=> st_r == ST_FAIL [*8])
      else $error("failure state left");
  AST_FLOAT_FIRST: // [R8]
    assert property ($rose(pins.bus_grant_out) |-> $past(st_r) == ST_FLOAT
                     && !pins.control_oe && !pins.shared_bus_oe)
      else $error("grant without prior float");
  AST_GRANT_DROP: // [R9]
    assert property (st_r == ST_HOLD && !req_f |=> !pins.bus_grant_out
                     && (st_r == ST_IDLE || st_r == ST_ADDR))
      else $error("grant not released");
  AST_GRANT_DRIVEN: // [R10]
    assert property (!once_r |-> pins.bus_grant_oe)
      else $error("grant output floating");
  AST_LAST_LOW: // [R11]
    assert property (st_r == ST_DATA && cnt_r == '0 && !once_r
                     |-> !pins.burst_final_marker_n)
      else $error("final marker high on last transfer");
  AST_WAIT: // [R13]
    assert property (st_r == ST_DATA && rdy_n_f
                     |=> st_r == ST_DATA && $stable(idx_r))
      else $error("phase advanced without ready");
  AST_INDEX: // [R14]
    assert property (st_r == ST_DATA && xfer && cnt_r != '0
                     |=> idx_r == $past(idx_r) + 3'h1
                     && pins.word_index_lines == idx_r)
      else $error("word index did not step");

endmodule
`default_nettype wire

// >>> common/burst_bus_pkg.sv
`default_nettype none
package burst_bus_pkg;

  localparam int unsigned SELFTEST_DEFAULT = 24000;
  localparam int TEST_CNT_W = 16;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 32;
  localparam int SUM_W = 32;
  localparam int IDX_W = 3;
  localparam int IDX_LO = 1;
  localparam int IDX_HI = 3;
  localparam int FIFO_DEPTH = 16;

  // Eight 32-bit words are read as two bursts of eight halfwords
  localparam logic [IDX_W-1:0] CHK_LAST_CNT = 3'h7;
  localparam logic [ADDR_W-1:0] CHK_FIRST_ADDR = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] CHK_SECOND_ADDR = 32'h0000_0010;
  localparam logic [1:0] BOTH_LANES = 2'h3;
  localparam logic [1:0] NO_LANES_N = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [IDX_W-1:0] words_m1;
    logic [1:0] lanes;
  } bus_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] shared_bus_lines;
    logic shared_bus_oe;
    logic [ADDR_W-DATA_W-1:0] addr_high;
    logic addr_high_oe;
    logic [IDX_W-1:0] word_index_lines;
    logic word_index_oe;
    logic [1:0] byte_lane_selects_n;
    logic byte_lane_oe;
    logic burst_final_marker_n;
    logic burst_final_oe;
    logic addr_latch;
    logic addr_status_n;
    logic data_enable_n;
    logic write_not_read;
    logic control_oe;
    logic bus_grant_out;
    logic bus_grant_oe;
  } pins_t;

  localparam pins_t PINS_RESET = '{addr_status_n: 1'h1, data_enable_n: 1'h1,
                                   control_oe: 1'h1, bus_grant_oe: 1'h1,
                                   default: '0};

  typedef enum logic [2:0] {
    ST_TEST, ST_FAIL, ST_IDLE, ST_ADDR, ST_DATA, ST_FLOAT, ST_HOLD
  } bus_state_t;

endpackage
`default_nettype wire

// >>> rtl/stream_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // DEPTH must be a power of two; the extra pointer bit tells full from empty
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop;

  always_comb begin
    in_ready = (wr_r - rd_r) != (PW+1)'(DEPTH);
    out_valid = wr_r != rd_r;
    out_data = mem[rd_r[PW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_nxt = wr_r + (PW+1)'(push);
    rd_nxt = rd_r + (PW+1)'(pop);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_r[PW-1:0]] <= in_data;
    end
  end

endmodule
`default_nettype wire

// >>> sim/burst_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module burst_mem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Controls from the bench
  input wire logic bad_sum,
  input wire logic [3:0] wait_cycles,
  // Bus pins
  input wire burst_bus_pkg::pins_t pins,
  output logic [15:0] shared_bus_in,
  output logic ready_n
);
  import burst_bus_pkg::*;
  logic [3:0] cnt_r;
  logic a4_r;
  logic [2:0] idx_r;
  // Eight words summing to zero only through a carry out of bit 31
  function automatic logic [15:0] word(input int i);
    case (i)
      2: word = 16'h1234;
      4: word = 16'hedcc;
      5: word = 16'hffff;
      default: word = 16'h0000;
    endcase
  endfunction
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r <= 4'h0;
      a4_r <= 1'b0;
      idx_r <= 3'h0;
      ready_n <= 1'b1;
      shared_bus_in <= 16'h5a5a;
    end else begin
      idx_r <= pins.word_index_lines;
      if (pins.addr_latch) begin
        a4_r <= pins.shared_bus_lines[4];
      end
      if (!pins.data_enable_n && !pins.write_not_read) begin
        shared_bus_in <= word({a4_r, pins.word_index_lines}) ^
                         {15'h0, bad_sum};
      end else begin
        // Released lines do not keep the last value
        shared_bus_in <= ~shared_bus_in;
      end
      // Ready withheld wait_cycles+2 per phase so the high level outlasts
      // the pin filter, then held until the index moves
      if (pins.data_enable_n || pins.word_index_lines != idx_r) begin
        cnt_r <= 4'h0;
        ready_n <= 1'b1;
      end else if (cnt_r == wait_cycles + 4'h1) begin
        ready_n <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_bus_hold_burst_init_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bus_hold_burst_init_status;
  import burst_bus_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  bus_req_t req = '0;
  logic rdata_ready = 1'b0;
  logic selftest_fault = 1'b0;
  logic bus_request = 1'b0;
  logic bus_guard_n = 1'b1;
  logic bad_sum = 1'b0;
  logic [3:0] wait_cycles = 4'h0;
  logic wdata_valid = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic grant_out, den_n, final_n;
  logic req_ready, wdata_ready, rdata_valid, init_done, init_failed;
  logic ready_n;
  logic [15:0] rdata, shared_bus_in;
  pins_t pins;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  assign grant_out = pins.bus_grant_out;
  assign den_n = pins.data_enable_n;
  assign final_n = pins.burst_final_marker_n;
  always #20 clock = ~clock;
  burst_bus_unit #(.SELFTEST_CYCLES(20)) uut (
    .clock(clock), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .wdata_valid(wdata_valid),
    .wdata_ready(wdata_ready), .wdata(wdata),
    .rdata_valid(rdata_valid), .rdata_ready(rdata_ready), .rdata(rdata),
    .selftest_fault(selftest_fault), .init_done(init_done),
    .init_failed(init_failed), .shared_bus_in(shared_bus_in),
    .ready_n(ready_n), .bus_request(bus_request),
    .bus_guard_n(bus_guard_n), .pins(pins));
  burst_mem_model mem_model (
    .clock(clock), .reset(reset), .bad_sum(bad_sum),
    .wait_cycles(wait_cycles), .pins(pins),
    .shared_bus_in(shared_bus_in), .ready_n(ready_n));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clock);
      #2;
    end
  endtask
  // Bounded wait on a design flag; gives up so the check reports it
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    for (int i = 0; i < lim && sig !== lvl; i++) begin
      tick();
    end
  endtask
  task automatic do_reset();
    reset = 1'b1;
    tick(6);
    check(pins.bus_grant_out, 1'b0);
    check(pins.bus_grant_oe, 1'b1);
    check(pins.shared_bus_oe, 1'b0);
    tick(6);
    reset = 1'b0;
    tick(3);
  endtask
  task automatic t_init_pass();
    do_reset();
    check(pins.burst_final_marker_n, 1'b0);
    check(pins.byte_lane_selects_n, 2'h3);
    check(pins.burst_final_oe, 1'b1);
    wait_for(init_done, 1'b1, 2000);
    check(init_done, 1'b1);
    check(init_failed, 1'b0);
  endtask
  task automatic t_init_fail(input logic fault, input logic bad);
    selftest_fault = fault;
    bad_sum = bad;
    do_reset();
    wait_for(init_failed, 1'b1, 400);
    tick(50);
    check(init_failed, 1'b1);
    check(init_done, 1'b0);
    check(pins.burst_final_marker_n, 1'b0);
    check(pins.byte_lane_selects_n, 2'h3);
    selftest_fault = 1'b0;
    bad_sum = 1'b0;
  endtask
  // Request held until an edge at which the one-cycle req_ready stood high
  task automatic core_req(input bus_req_t r);
    req = r;
    req_valid = 1'b1;
    #1;
    for (int i = 0; i < 400 && req_ready !== 1'b1; i++) begin
      tick();
    end
    check(req_ready, 1'b1);
    tick();
    req_valid = 1'b0;
  endtask
  task automatic core_read(input logic [31:0] addr);
    core_req('{addr: addr, write: 1'b0, words_m1: 3'h7, lanes: BOTH_LANES});
  endtask
  // Two-word write on the upper lane only
  task automatic t_write();
    wdata = 16'hc3a5;
    wdata_valid = 1'b1;
    core_req('{addr: 32'h0000_0020, write: 1'b1, words_m1: 3'h1,
               lanes: 2'h2});
    wait_for(den_n, 1'b0, 20);
    check(pins.write_not_read, 1'b1);
    check(pins.shared_bus_oe, 1'b1);
    check(pins.shared_bus_lines, 16'hc3a5);
    check(pins.byte_lane_selects_n, 2'h1);
    check(pins.burst_final_marker_n, 1'b1);
    wait_for(final_n, 1'b0, 40);
    check(pins.word_index_lines, 3'h1);
    check(pins.data_enable_n, 1'b0);
    wait_for(den_n, 1'b1, 40);
    check(pins.burst_final_marker_n, 1'b1);
    wdata_valid = 1'b0;
  endtask
  // Two 8-word bursts fill the buffer while the reader stalls
  task automatic t_read_fill();
    wait_cycles = 4'h2;
    core_read(32'h0000_0000);
    core_read(32'h0000_0010);
    tick(3);
    wait_for(den_n, 1'b1, 400);
    tick(10);
    for (int i = 0; i < 16; i++) begin
      wait_for(rdata_valid, 1'b1, 50);
      check(rdata_valid, 1'b1);
      check(rdata, mem_model.word(i));
      rdata_ready = 1'b1;
      tick();
      rdata_ready = 1'b0;
      tick();
    end
    check(rdata_valid, 1'b0);
    wait_cycles = 4'h0;
  endtask
  task automatic t_hold();
    bus_request = 1'b1;
    wait_for(grant_out, 1'b1, 100);
    check(pins.bus_grant_out, 1'b1);
    check(pins.shared_bus_oe, 1'b0);
    check(pins.byte_lane_oe, 1'b0);
    check(pins.burst_final_oe, 1'b0);
    tick(5);
    bus_request = 1'b0;
    wait_for(grant_out, 1'b0, 100);
    check(pins.bus_grant_out, 1'b0);
    check(pins.bus_grant_oe, 1'b1);
  endtask
  task automatic t_float();
    bus_guard_n = 1'b0;
    do_reset();
    bus_guard_n = 1'b1;
    tick(40);
    check(pins.bus_grant_oe, 1'b0);
    check(pins.control_oe, 1'b0);
    check(pins.burst_final_oe, 1'b0);
    check(pins.shared_bus_oe, 1'b0);
    check(pins.byte_lane_oe, 1'b0);
  endtask
  initial begin
    t_init_pass();
    t_read_fill();
    t_hold();
    t_write();
    t_init_fail(1'b1, 1'b0);
    t_init_fail(1'b0, 1'b1);
    t_float();
    t_init_pass();
    wrap_up();
  end
endmodule
`default_nettype wire
